// [design/homing_map.vh]
// register map, field codes and reset values of the homing sequencer
`ifndef HOMING_MAP_VH
`define HOMING_MAP_VH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define IDX_SEEK_MODE 15'h4160
`define IDX_START_DIR 15'h4161
`define IDX_START_SPEED 15'h4163
`define IDX_SENSOR_INPUT_A_DET 15'h4166
`define IDX_OUT_QUAL 15'h4167
`define IDX_BACKOFF 15'h4169
`define IDX_ONE_WAY 15'h416a
`define IDX_METHOD 15'h6098
`define IDX_SWITCH_SPEED 15'h6099
`define IDX_ACCEL 15'h609a
`define IDX_ZERO_SPEED 15'h7000
`define IDX_CONTROL 15'h7001
`define IDX_STATUS 15'h7002
`define IDX_INT_STATUS 15'h7003
`define IDX_INT_CLEAR 15'h7004
`define IDX_INT_ENABLE 15'h7005
`define IDX_CUR_POS 15'h7006
`define IDX_HOME_POS 15'h7007

// ****************************************************************
// field codes
// ****************************************************************
`define MODE_TWO_SENSOR 8'h00
`define MODE_THREE_SENSOR 8'h01
`define MODE_ONE_WAY 8'h02
`define DIR_POSITIVE 8'h01
`define QUAL_NONE 8'h00
`define QUAL_TIMING 8'h01
`define QUAL_ZERO 8'h02
`define METH_LIMIT_NEG 8'h11
`define METH_LIMIT_POS 8'h12
`define METH_HOME_POS 8'h18
`define METH_HOME_NEG 8'h1c
`define METH_PRESET_A 8'h23
`define METH_PRESET_B 8'h25
`define METH_VENDOR 8'hff
`define ALARM_HOME_ERR 8'h62
`define CTRL_START_BIT 0
`define CTRL_PRESET_BIT 1
`define INT_DONE_BIT 0
`define INT_REJECT_BIT 1
`define INT_ALARM_BIT 2
`define INT_BITS 3

// ****************************************************************
// reset values
// ****************************************************************
`define RST_SEEK_MODE 8'h02
`define RST_START_DIR 8'h01
`define RST_START_SPEED 32'h0000_1388
`define RST_BACKOFF 32'h0000_1388
`define RST_ONE_WAY 32'h0000_1388
`define RST_METHOD 8'h18
`define RST_SWITCH_SPEED 32'h0000_2710
`define RST_ZERO_SPEED 32'h0000_1388
`define RST_ACCEL 32'h0004_93e0

`endif

// [design/travel_counter.v]
// step counter that ends a fixed-distance move
`timescale 1ns/1ps

module travel_counter (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [31:0] amount,
  input wire step,
  output wire done
);
  reg [31:0] left_ff;
  reg [31:0] nxt_left;

  always @* begin
    nxt_left = left_ff;
    if (load) begin
      nxt_left = amount;
    end else if (step && (left_ff != 32'h0000_0000)) begin
      nxt_left = left_ff - 32'h0000_0001;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      left_ff <= 32'h0000_0000;
    end else begin
      left_ff <= nxt_left;
    end
  end

  // a zero amount is done the cycle after the load, with no step
  assign done = (left_ff == 32'h0000_0000) && !load;
endmodule // travel_counter

// [design/homing_sequencer.v]
// return-to-home sequencer with apb register file
`timescale 1ns/1ps
`include "homing_map.vh"

// Function
// - method 24: go positive, leave home at start speed, stop on home ON.
// - method 28: same home-sensor sequence, first travel negative.
// - mode 1 is 3-sensor, 0 is 2-sensor; direction 1 positive, 0 negative.
// - methods 17/18: leave limit, travel backoff steps, stop, record home.
// - standard methods apply no sensor_input_a or output qualifier.
// - methods 35/37 preset home at once, refused while operation enabled.
// - 3-sensor: switch speed, reverse off limit, stop on home ON edge.
// - 3-sensor qualifier: keep moving until output seen with home active.
// - 2-sensor: start speed, reverse off limit, backoff steps, record home.
// - 2-sensor qualifier: keep moving until selected output is seen.
// - one-way: decel stop at home, leave at zero speed, travel, record.
// - home lost during one-way decel stop raises alarm 62h.
// - method -1 selects vendor mode from mode, direction and qualifier.
module homing_sequencer (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [16:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  input wire home_sensor_input,
  input wire forward_limit_input,
  input wire reverse_limit_input,
  input wire step_timing_output,
  input wire encoder_zero_output,
  input wire op_enabled,
  input wire step_pulse,
  input wire motion_stopped,
  output reg move_en_ff,
  output reg move_dir_ff,
  output reg [31:0] move_speed_ff,
  output reg [31:0] accel_ff,
  output reg irq_ff
);
  // ****************************************************************
  // states and profiles
  // ****************************************************************
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_SEEK = 3'd1;
  localparam [2:0] S_LEAVE = 3'd2;
  localparam [2:0] S_APPROACH = 3'd3;
  localparam [2:0] S_BACKOFF = 3'd4;
  localparam [2:0] S_DECEL = 3'd5;
  localparam [2:0] S_QUAL = 3'd6;
  localparam [2:0] S_STOP = 3'd7;
  localparam [1:0] P_HOME = 2'd0;
  localparam [1:0] P_TWO = 2'd1;
  localparam [1:0] P_ONE = 2'd2;

  function [4:0] reg_sel;
    input [16:0] a;
    begin
      case (a[16:2])
        `IDX_SEEK_MODE: reg_sel = 5'd1;
        `IDX_START_DIR: reg_sel = 5'd2;
        `IDX_START_SPEED: reg_sel = 5'd3;
        `IDX_SENSOR_INPUT_A_DET: reg_sel = 5'd4;
        `IDX_OUT_QUAL: reg_sel = 5'd5;
        `IDX_BACKOFF: reg_sel = 5'd6;
        `IDX_ONE_WAY: reg_sel = 5'd7;
        `IDX_METHOD: reg_sel = 5'd8;
        `IDX_SWITCH_SPEED: reg_sel = 5'd9;
        `IDX_ACCEL: reg_sel = 5'd10;
        `IDX_ZERO_SPEED: reg_sel = 5'd11;
        `IDX_CONTROL: reg_sel = 5'd12;
        `IDX_STATUS: reg_sel = 5'd13;
        `IDX_INT_STATUS: reg_sel = 5'd14;
        `IDX_INT_CLEAR: reg_sel = 5'd15;
        `IDX_INT_ENABLE: reg_sel = 5'd16;
        `IDX_CUR_POS: reg_sel = 5'd17;
        `IDX_HOME_POS: reg_sel = 5'd18;
        default: reg_sel = 5'd0;
      endcase
    end
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [7:0] seek_mode_ff;
  reg [7:0] start_dir_ff;
  reg [31:0] start_speed_ff;
  reg [7:0] sensor_input_a_det_ff;
  reg [7:0] out_qual_ff;
  reg [31:0] backoff_ff;
  reg [31:0] one_way_ff;
  reg [7:0] method_ff;
  reg [31:0] switch_speed_ff;
  reg [31:0] zero_speed_ff;
  reg [`INT_BITS-1:0] int_status_ff;
  reg [`INT_BITS-1:0] int_enable_ff;
  reg [31:0] cur_pos_ff;
  reg [31:0] home_pos_ff;
  reg [7:0] alarm_ff;
  reg complete_ff;
  reg [2:0] state_ff;
  reg [1:0] prof_ff;
  reg qual_ff;
  reg [1:0] qual_sel_ff;
  reg dir_ff;
  reg home_q_ff;
  reg [2:0] nxt_state;
  reg nxt_dir;
  reg nxt_en;
  reg [31:0] nxt_speed;
  reg ev_done;
  reg ev_reject;
  reg ev_alarm;
  reg ld_cnt;
  reg [31:0] ld_amount;
  reg [31:0] nxt_rdata;
  wire setup = psel && !penable;
  wire wr_go = psel && penable && pready_ff && pwrite;
  wire [4:0] wsel = reg_sel(paddr);
  wire start_req = wr_go && (wsel == 5'd12) && pwdata[`CTRL_START_BIT];
  wire preset_req = wr_go && (wsel == 5'd12)
    && pwdata[`CTRL_PRESET_BIT];
  wire busy = (state_ff != S_IDLE);
  wire fwd_lim = dir_ff ? forward_limit_input : reverse_limit_input;
  wire any_lim = forward_limit_input || reverse_limit_input;
  wire home_on = home_sensor_input && !home_q_ff;
  wire qual_hit = (qual_sel_ff == 2'd1) ? step_timing_output
    : encoder_zero_output;
  wire cnt_done;
  wire [`INT_BITS-1:0] ev_vec = {ev_alarm, ev_reject, ev_done};

  travel_counter u_travel (
    .clk(clk),
    .rst_n(rst_n),
    .load(ld_cnt),
    .amount(ld_amount),
    .step(step_pulse),
    .done(cnt_done)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always @* begin
    nxt_state = state_ff;
    nxt_dir = dir_ff;
    nxt_en = move_en_ff;
    nxt_speed = move_speed_ff;
    ev_done = 1'b0;
    ev_reject = 1'b0;
    ev_alarm = 1'b0;
    ld_cnt = 1'b0;
    ld_amount = backoff_ff;
    case (state_ff)
      S_IDLE: begin
        nxt_en = 1'b0;
        if (preset_req) begin
          if (op_enabled) begin
            ev_reject = 1'b1;
          end else begin
            ev_done = 1'b1;
          end
        end else if (start_req) begin
          nxt_state = S_SEEK;
          nxt_en = 1'b1;
          nxt_speed = switch_speed_ff;
          case (method_ff)
            `METH_HOME_POS: nxt_dir = 1'b1;
            `METH_HOME_NEG: nxt_dir = 1'b0;
            `METH_LIMIT_NEG: begin
              nxt_dir = 1'b0;
              nxt_speed = start_speed_ff;
            end
            `METH_LIMIT_POS: begin
              nxt_dir = 1'b1;
              nxt_speed = start_speed_ff;
            end
            `METH_PRESET_A, `METH_PRESET_B: begin
              nxt_state = S_IDLE;
              nxt_en = 1'b0;
              if (op_enabled) begin
                ev_reject = 1'b1;
              end else begin
                ev_done = 1'b1;
              end
            end
            `METH_VENDOR: begin
              nxt_dir = (start_dir_ff == `DIR_POSITIVE);
              if (seek_mode_ff == `MODE_TWO_SENSOR) begin
                nxt_speed = start_speed_ff;
              end else if (seek_mode_ff > `MODE_ONE_WAY) begin
                nxt_state = S_IDLE;
                nxt_en = 1'b0;
                ev_reject = 1'b1;
              end
            end
            default: begin
              nxt_state = S_IDLE;
              nxt_en = 1'b0;
              ev_reject = 1'b1;
            end
          endcase
        end
      end
      S_SEEK: begin
        if (prof_ff == P_ONE) begin
          if (home_sensor_input) begin
            nxt_en = 1'b0;
            nxt_state = S_DECEL;
          end
        end else if (prof_ff == P_TWO) begin
          if (fwd_lim) begin
            nxt_dir = !dir_ff;
            nxt_state = S_LEAVE;
          end
        end else if (home_sensor_input) begin
          nxt_dir = !dir_ff;
          nxt_speed = start_speed_ff;
          nxt_state = S_LEAVE;
        end else if (fwd_lim) begin
          nxt_dir = !dir_ff;
        end
      end
      S_DECEL: begin
        if (!home_sensor_input) begin
          ev_alarm = 1'b1;
          nxt_state = S_IDLE;
        end else if (motion_stopped) begin
          nxt_en = 1'b1;
          nxt_speed = zero_speed_ff;
          nxt_state = S_LEAVE;
        end
      end
      S_LEAVE: begin
        if (prof_ff == P_TWO) begin
          if (!any_lim) begin
            ld_cnt = 1'b1;
            nxt_state = S_BACKOFF;
          end
        end else if (!home_sensor_input) begin
          if (prof_ff == P_ONE) begin
            ld_cnt = 1'b1;
            ld_amount = one_way_ff;
            nxt_state = S_BACKOFF;
          end else begin
            nxt_dir = !dir_ff;
            nxt_speed = zero_speed_ff;
            nxt_state = S_APPROACH;
          end
        end
      end
      S_APPROACH: begin
        if (home_on) begin
          if (qual_ff) begin
            nxt_state = S_QUAL;
          end else begin
            nxt_en = 1'b0;
            nxt_state = S_STOP;
          end
        end
      end
      S_BACKOFF: begin
        if (cnt_done) begin
          if (qual_ff && (prof_ff == P_TWO)) begin
            nxt_state = S_QUAL;
          end else begin
            nxt_en = 1'b0;
            nxt_state = S_STOP;
          end
        end
      end
      S_QUAL: begin
        if (qual_hit && ((prof_ff == P_TWO) || home_sensor_input)) begin
          nxt_en = 1'b0;
          nxt_state = S_STOP;
        end
      end
      S_STOP: begin
        if (motion_stopped) begin
          ev_done = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
        nxt_en = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      prof_ff <= P_HOME;
      qual_ff <= 1'b0;
      qual_sel_ff <= 2'd0;
      dir_ff <= 1'b0;
      home_q_ff <= 1'b0;
      move_en_ff <= 1'b0;
      move_dir_ff <= 1'b0;
      move_speed_ff <= 32'h0000_0000;
      cur_pos_ff <= 32'h0000_0000;
      home_pos_ff <= 32'h0000_0000;
      complete_ff <= 1'b0;
      alarm_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      dir_ff <= nxt_dir;
      move_dir_ff <= nxt_dir;
      move_en_ff <= nxt_en;
      move_speed_ff <= nxt_speed;
      home_q_ff <= home_sensor_input;
      if (!busy && start_req) begin
        complete_ff <= 1'b0;
        alarm_ff <= 8'h00;
        // standard methods run unqualified
        qual_ff <= (method_ff == `METH_VENDOR)
          && (out_qual_ff != `QUAL_NONE);
        qual_sel_ff <= out_qual_ff[1:0];
        if ((method_ff == `METH_LIMIT_NEG)
            || (method_ff == `METH_LIMIT_POS)) begin
          prof_ff <= P_TWO;
        end else if (method_ff == `METH_VENDOR) begin
          if (seek_mode_ff == `MODE_TWO_SENSOR) begin
            prof_ff <= P_TWO;
          end else if (seek_mode_ff == `MODE_ONE_WAY) begin
            prof_ff <= P_ONE;
          end else begin
            prof_ff <= P_HOME;
          end
        end else begin
          prof_ff <= P_HOME;
        end
      end
      if (ev_alarm) begin
        alarm_ff <= `ALARM_HOME_ERR;
      end
      if (ev_done) begin
        // stop point kept relative to the previous home, current position becomes home
        home_pos_ff <= cur_pos_ff;
        cur_pos_ff <= 32'h0000_0000;
        complete_ff <= 1'b1;
      end else if (step_pulse) begin
        cur_pos_ff <= move_dir_ff ? cur_pos_ff + 32'h0000_0001
          : cur_pos_ff - 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // apb slave, zero wait states
  // ****************************************************************
  always @* begin
    case (wsel)
      5'd1: nxt_rdata = {24'h00_0000, seek_mode_ff};
      5'd2: nxt_rdata = {24'h00_0000, start_dir_ff};
      5'd3: nxt_rdata = start_speed_ff;
      5'd4: nxt_rdata = {24'h00_0000, sensor_input_a_det_ff};
      5'd5: nxt_rdata = {24'h00_0000, out_qual_ff};
      5'd6: nxt_rdata = backoff_ff;
      5'd7: nxt_rdata = one_way_ff;
      5'd8: nxt_rdata = {24'h00_0000, method_ff};
      5'd9: nxt_rdata = switch_speed_ff;
      5'd10: nxt_rdata = accel_ff;
      5'd11: nxt_rdata = zero_speed_ff;
      5'd13: nxt_rdata = {16'h0000, alarm_ff, 3'd0, state_ff,
        complete_ff, busy};
      5'd14: nxt_rdata = {29'h0, int_status_ff};
      5'd16: nxt_rdata = {29'h0, int_enable_ff};
      5'd17: nxt_rdata = cur_pos_ff;
      5'd18: nxt_rdata = home_pos_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && (wsel == 5'd0);
      if (setup) begin
        prdata_ff <= nxt_rdata;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      seek_mode_ff <= `RST_SEEK_MODE;
      start_dir_ff <= `RST_START_DIR;
      start_speed_ff <= `RST_START_SPEED;
      sensor_input_a_det_ff <= 8'h00;
      out_qual_ff <= `QUAL_NONE;
      backoff_ff <= `RST_BACKOFF;
      one_way_ff <= `RST_ONE_WAY;
      method_ff <= `RST_METHOD;
      switch_speed_ff <= `RST_SWITCH_SPEED;
      zero_speed_ff <= `RST_ZERO_SPEED;
      accel_ff <= `RST_ACCEL;
      int_enable_ff <= {`INT_BITS{1'b0}};
    end else if (wr_go) begin
      case (wsel)
        5'd1: seek_mode_ff <= pwdata[7:0];
        5'd2: start_dir_ff <= pwdata[7:0];
        5'd3: start_speed_ff <= pwdata;
        5'd4: sensor_input_a_det_ff <= pwdata[7:0];
        5'd5: out_qual_ff <= pwdata[7:0];
        5'd6: backoff_ff <= pwdata;
        5'd7: one_way_ff <= pwdata;
        5'd8: method_ff <= pwdata[7:0];
        5'd9: switch_speed_ff <= pwdata;
        5'd10: accel_ff <= pwdata;
        5'd11: zero_speed_ff <= pwdata;
        5'd16: int_enable_ff <= pwdata[`INT_BITS-1:0];
        default: accel_ff <= accel_ff;
      endcase
    end
  end

  // ****************************************************************
  // interrupts, set wins over clear
  // ****************************************************************
  wire clr_go = wr_go && (wsel == 5'd15);
  genvar gi;
  generate
    for (gi = 0; gi < `INT_BITS; gi = gi + 1) begin : g_int
      always @(posedge clk) begin
        if (!rst_n) begin
          int_status_ff[gi] <= 1'b0;
        end else if (ev_vec[gi]) begin
          int_status_ff[gi] <= 1'b1;
        end else if (clr_go && pwdata[gi]) begin
          int_status_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(int_status_ff & int_enable_ff);
    end
  end
endmodule // homing_sequencer

// [tb/homing_sequencer_props.sv]
// assertion checker on the homing sequencer ports
`timescale 1ns/1ps
`include "homing_map.vh"
module homing_checker (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [16:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata_ff,
  input wire pready_ff,
  input wire pslverr_ff,
  input wire home_sensor_input,
  input wire forward_limit_input,
  input wire reverse_limit_input,
  input wire step_timing_output,
  input wire encoder_zero_output,
  input wire op_enabled,
  input wire step_pulse,
  input wire motion_stopped,
  input wire move_en_ff,
  input wire move_dir_ff,
  input wire [31:0] move_speed_ff,
  input wire [31:0] accel_ff,
  input wire irq_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // named steps
  // ****************************************
  wire acc = psel && penable && pready_ff && pwrite;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence preset_s;
    acc && paddr[16:2] == `IDX_CONTROL && pwdata[1] && op_enabled;
  endsequence
  sequence clear_s;
    acc && paddr[16:2] == `IDX_INT_CLEAR && pwdata[2:0] == 3'h7;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  chk_ready_answer: assert property (setup_s |=> pready_ff)
    else $error("setup not answered next cycle");
  chk_ready_pulse: assert property (pready_ff |=> !pready_ff)
    else $error("ready held past one cycle");
  chk_err_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");
  chk_preset_refused: assert property (
    preset_s ##0 !move_en_ff |=> !move_en_ff [*3])
    else $error("preset moved while operation enabled");
  chk_stop_home: assert property (
    move_en_ff && move_speed_ff == `RST_ZERO_SPEED && $rose(home_sensor_input)
    |-> ##[1:3] !move_en_ff)
    else $error("no stop on home edge");
  chk_fwd_limit: assert property (
    move_en_ff && move_dir_ff && forward_limit_input
    |-> ##[1:3] !(move_en_ff && move_dir_ff))
    else $error("forward limit not reversed");
  chk_rev_limit: assert property (
    move_en_ff && !move_dir_ff && reverse_limit_input
    |-> ##[1:3] !(move_en_ff && !move_dir_ff))
    else $error("reverse limit not reversed");
  chk_leave_switch: assert property (
    move_en_ff && move_speed_ff == `RST_SWITCH_SPEED && $rose(home_sensor_input)
    |-> ##[1:3] (!move_en_ff || move_speed_ff != `RST_SWITCH_SPEED))
    else $error("search speed kept after home");
  chk_irq_clear: assert property (clear_s |-> ##2 !irq_ff)
    else $error("interrupt not cleared");
endmodule // homing_checker

bind homing_sequencer homing_checker homing_checker_i (.clk(clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
  .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
  .home_sensor_input(home_sensor_input),
  .forward_limit_input(forward_limit_input),
  .reverse_limit_input(reverse_limit_input),
  .step_timing_output(step_timing_output),
  .encoder_zero_output(encoder_zero_output), .op_enabled(op_enabled),
  .step_pulse(step_pulse), .motion_stopped(motion_stopped),
  .move_en_ff(move_en_ff), .move_dir_ff(move_dir_ff),
  .move_speed_ff(move_speed_ff), .accel_ff(accel_ff), .irq_ff(irq_ff));

// [tb/motion_model.sv]
// motion generator and sensor stand model for the homing bench
`timescale 1ns/1ps
module motion_model (
  input wire clk,
  input wire rst_n,
  input wire move_en,
  input wire move_dir,
  input wire [7:0] decel_steps,
  input wire three_mode,
  output reg step_pulse,
  output wire motion_stopped,
  output wire home_sensor_input,
  output wire forward_limit_input,
  output wire reverse_limit_input,
  output wire step_timing_output,
  output wire encoder_zero_output
);
  integer pos_ff;
  reg [1:0] div_ff;
  reg [7:0] left_ff;
  reg dir_ff;
  wire go = move_en || left_ff != 8'h00;
  wire dir = move_en ? move_dir : dir_ff;
  assign home_sensor_input = pos_ff >= 100 && pos_ff <= 120;
  assign forward_limit_input = pos_ff >= 200;
  assign reverse_limit_input = !three_mode && pos_ff <= -50;
  assign step_timing_output = pos_ff[2:0] == 3'h0;
  assign encoder_zero_output = pos_ff[5:0] == 6'h00;
  // a small decel_steps stops inside the home window
  assign motion_stopped = !go;
  always @(posedge clk) begin
    step_pulse <= 1'b0;
    div_ff <= div_ff + 2'h1;
    if (!rst_n) begin
      pos_ff <= 0;
      div_ff <= 2'h0;
      left_ff <= 8'h00;
      dir_ff <= 1'b0;
    end else if (move_en) begin
      dir_ff <= move_dir;
      left_ff <= decel_steps;
    end else if (go && div_ff == 2'h3) begin
      left_ff <= left_ff - 8'h01;
    end
    if (rst_n && go && div_ff == 2'h3) begin
      step_pulse <= 1'b1;
      pos_ff <= dir ? pos_ff + 1 : pos_ff - 1;
    end
  end
endmodule // motion_model

// [tb/homing_sequencer_bench.sv]
// self-checking bench for the homing sequencer
`timescale 1ns/1ps
`include "homing_map.vh"
module homing_sequencer_bench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [16:0] paddr = 17'h0_0000;
  reg [31:0] pwdata = 32'h0000_0000;
  reg op_enabled = 1'b0;
  reg three_mode = 1'b0;
  reg [7:0] decel = 8'h00;
  reg [7:0] rnd = 8'h47;
  reg [32:0] exp_q[$];
  reg [32:0] msk_q[$];
  reg [32:0] e, m;
  wire [31:0] prdata_ff, move_speed_ff, accel_ff;
  wire pready_ff, pslverr_ff, move_en_ff, move_dir_ff, irq_ff;
  wire step_pulse, motion_stopped, home_sensor_input;
  wire forward_limit_input, reverse_limit_input;
  wire step_timing_output, encoder_zero_output;
  integer err_total = 0, num_checks = 0, cycles = 0;
  integer org = 0, last_hp = 0, bk, ow;
  always #25 clk = ~clk;
  homing_sequencer homing_sequencer_i (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .home_sensor_input(home_sensor_input),
    .forward_limit_input(forward_limit_input),
    .reverse_limit_input(reverse_limit_input),
    .step_timing_output(step_timing_output),
    .encoder_zero_output(encoder_zero_output), .op_enabled(op_enabled),
    .step_pulse(step_pulse), .motion_stopped(motion_stopped),
    .move_en_ff(move_en_ff), .move_dir_ff(move_dir_ff),
    .move_speed_ff(move_speed_ff), .accel_ff(accel_ff), .irq_ff(irq_ff));
  motion_model motion_model_i (.clk(clk), .rst_n(rst_n),
    .move_en(move_en_ff), .move_dir(move_dir_ff), .decel_steps(decel),
    .three_mode(three_mode), .step_pulse(step_pulse),
    .motion_stopped(motion_stopped), .home_sensor_input(home_sensor_input),
    .forward_limit_input(forward_limit_input),
    .reverse_limit_input(reverse_limit_input),
    .step_timing_output(step_timing_output),
    .encoder_zero_output(encoder_zero_output));
  // ****************************************
  // bus tasks and helpers
  // ****************************************
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task apb(input wr, input [14:0] idx, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready_ff !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [14:0] idx, input [31:0] ex, input [31:0] mk = 32'hffff_ffff,
    input er = 1'b0);
    begin
      exp_q.push_back({er, ex & mk});
      msk_q.push_back({1'b1, mk});
      apb(1'b0, idx, 32'h0000_0000);
    end
  endtask
  task irq_is(input v);
    begin
      num_checks = num_checks + 1;
      if (irq_ff !== v) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, irq_ff, v);
      end
    end
  endtask
  // one homing request, then its event, home and position
  task run(input [31:0] meth, input [31:0] md, input [31:0] dir,
    input [31:0] ctl, input integer stop, input [31:0] ib);
    begin
      wait (motion_stopped);
      apb(1'b1, `IDX_METHOD, meth);
      apb(1'b1, `IDX_SEEK_MODE, md);
      apb(1'b1, `IDX_START_DIR, dir);
      apb(1'b1, `IDX_CONTROL, ctl);
      while (irq_ff !== 1'b1) @(posedge clk);
      rd(`IDX_INT_STATUS, ib);
      apb(1'b1, `IDX_INT_CLEAR, 32'h0000_0007);
      if (ib == 32'h0000_0001) begin
        last_hp = stop - org;
        org = stop;
        rd(`IDX_CUR_POS, 32'h0000_0000);
        rd(`IDX_STATUS, 32'h0000_0002, 32'h0000_0003);
      end
      rd(`IDX_HOME_POS, last_hp);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // ****************************************
  // read monitor and hang guard
  // ****************************************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      err_total = err_total + 1;
      finish_test;
    end
    if (psel && penable && pready_ff && !pwrite) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      num_checks = num_checks + 1;
      if (({pslverr_ff, prdata_ff} & m) !== e) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time,
          {pslverr_ff, prdata_ff} & m, e);
      end
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(`IDX_ACCEL, `RST_ACCEL);
    rd(`IDX_METHOD, `RST_METHOD);
    rd(`IDX_SEEK_MODE, `RST_SEEK_MODE);
    rd(`IDX_START_DIR, `RST_START_DIR);
    rd(`IDX_SWITCH_SPEED, `RST_SWITCH_SPEED);
    rd(`IDX_SENSOR_INPUT_A_DET, 32'h0000_0000);
    rd(`IDX_OUT_QUAL, `QUAL_NONE);
    rd(15'h4162, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    rnd = lfsr(rnd);
    bk = rnd[2:0] + 2;
    rnd = lfsr(rnd);
    ow = rnd[2:0] + 2;
    // start speed apart from zero speed
    apb(1'b1, `IDX_START_SPEED, 32'h0000_3000);
    apb(1'b1, `IDX_BACKOFF, bk);
    apb(1'b1, `IDX_ONE_WAY, ow);
    apb(1'b1, `IDX_INT_ENABLE, 32'h0000_0007);
    rd(`IDX_START_SPEED, 32'h0000_3000);
    rd(`IDX_BACKOFF, bk);
    run(`METH_VENDOR, `MODE_ONE_WAY, 1, 1, 121 + ow, 1);
    run(`METH_LIMIT_NEG, 0, 0, 1, bk - 49, 1);
    run(`METH_HOME_POS, 0, 0, 1, 100, 1);
    run(`METH_LIMIT_POS, 0, 0, 1, 199 - bk, 1);
    run(`METH_HOME_NEG, 0, 0, 1, 120, 1);
    run(`METH_VENDOR, `MODE_TWO_SENSOR, 0, 1, bk - 49, 1);
    apb(1'b1, `IDX_OUT_QUAL, 1);
    run(`METH_VENDOR, `MODE_TWO_SENSOR, 0, 1, (bk - 42) & -8, 1);
    decel <= 8'h1e;
    run(`METH_VENDOR, `MODE_ONE_WAY, 1, 1, 0, 4);
    rd(`IDX_STATUS, 32'h0000_6200, 32'h0000_ff00);
    decel <= 8'h00;
    run(`METH_PRESET_A, 0, 0, 2, 130, 1);
    three_mode <= 1'b1;
    run(`METH_VENDOR, `MODE_THREE_SENSOR, 1, 1, 120, 1);
    op_enabled <= 1'b1;
    run(`METH_PRESET_B, 0, 0, 2, 0, 2);
    op_enabled <= 1'b0;
    run(`METH_VENDOR, 8'h03, 1, 1, 0, 2);
    // refused start with its event masked off
    apb(1'b1, `IDX_INT_ENABLE, 32'h0000_0005);
    apb(1'b1, `IDX_METHOD, 32'h0000_0005);
    apb(1'b1, `IDX_CONTROL, 32'h0000_0001);
    repeat (4) @(posedge clk);
    irq_is(1'b0);
    rd(`IDX_INT_STATUS, 32'h0000_0002);
    apb(1'b1, `IDX_INT_ENABLE, 32'h0000_0007);
    repeat (3) @(posedge clk);
    irq_is(1'b1);
    apb(1'b1, `IDX_INT_CLEAR, 32'h0000_0007);
    rd(`IDX_HOME_POS, last_hp);
    repeat (3) @(posedge clk);
    finish_test;
  end
endmodule // homing_sequencer_bench
